// >>> hrap_device.sv
// Adapter end of the host register access port: eight 16-bit registers
// plus an interrupt vector, reached by the host over the parallel bus.
// Assumes host inputs synchronous to core_clk; the testbench resolves wires.
//
// What the port does, device end and host end
// - Read starts when select, read strobe, not busy
// - Read buffer enable is combinational from inputs
// - Write starts when select, write strobe, not busy
// - Write buffer enable on third rising edge
// - Write data captured on sixth rising edge
// - Drive ready high before releasing it
// - Write buffer enable drops on the same edge ready asserts
// - Host holds address until ready asserts
// - Address latch strobe latches select lines
// - Eight-bit reads float high data lines
// - Eight-bit writes ignore high data lines
// - Host waits after ready before releasing strobes
// - Host releases strobes within 1000 ns
// - Interrupt acknowledge and select never overlap
// - Two acknowledge pulses, first at least 150 ns
// - Data strobe high 100 ns between accesses
// - Select and acknowledge both high 100 ns
// - Later of two strobes counts; skew 10 ns
// - Direction low during writes, high after
`timescale 1ns/1ps
`default_nettype none
module hrap_device #(
    parameter int unsigned DATA_W = hrap_pkg::DATA_W,
    parameter int unsigned SEL_W = hrap_pkg::SEL_W,
    parameter logic [hrap_pkg::VEC_W-1:0] VECTOR = hrap_pkg::VEC_RESET
) (
    input wire logic core_clk,
    input wire logic rst_b,
    hrap_if.device bus,
    input wire logic int_vec_load,
    input wire logic [hrap_pkg::VEC_W-1:0] int_vec_in,
    output logic [DATA_W-1:0] reg0_value,
    output logic write_done
);
    localparam int unsigned NREG = 1 << SEL_W;
    hrap_pkg::hrap_dev_state_e state_q, state_d;
    logic [DATA_W-1:0] regs_q [NREG];
    logic [SEL_W-1:0] sel_lat_q;
    logic cs_lat_q, bhe_lat_q;
    logic [3:0] cnt_q;
    logic buf_wr_q, dir_q, rdy_out_q, rdy_oe_n_q;
    logic [DATA_W-1:0] rd_data_q;
    logic rd_oe_n_q, hi_oe_n_q, is_iack_q, write_done_q;
    logic [hrap_pkg::VEC_W-1:0] vec_q;
    logic [DATA_W-1:0] reg0_q;

    // Transparent while the latch strobe is high, held while it is low
    wire logic [SEL_W-1:0] sel_eff = bus.addr_latch_strobe ? bus.reg_select : sel_lat_q;
    wire logic cs_eff = bus.addr_latch_strobe ? bus.host_chip_sel_n : cs_lat_q;
    wire logic bhe_eff = bus.addr_latch_strobe ? bus.byte_high_en_n : bhe_lat_q;
    // Later of the two data strobes: both must be low
    wire logic ds_both = ~bus.lower_strobe_n & ~bus.upper_strobe_n;
    wire logic rd_req = bus.acknowledge_style_mode ? (ds_both & bus.read_not_write)
                                                   : ~bus.rd_strobe_n;
    wire logic wr_req = bus.acknowledge_style_mode ? (ds_both & ~bus.read_not_write)
                                                   : ~bus.wr_strobe_n;
    wire logic cs_act = ~(bus.acknowledge_style_mode ? bus.host_chip_sel_n : cs_eff);
    wire logic busy = (state_q != hrap_pkg::HRAP_IDLE);
    wire logic rd_start = cs_act & rd_req & ~busy;
    wire logic wr_start = cs_act & wr_req & ~busy;
    wire logic iack_start = ~bus.int_ack_n & rd_req & ~busy;
    wire logic strobe_gone = bus.acknowledge_style_mode
        ? (bus.lower_strobe_n | bus.upper_strobe_n | bus.host_chip_sel_n)
        : (bus.rd_strobe_n & bus.wr_strobe_n & bus.int_ack_n) | (cs_eff & bus.int_ack_n);
    // Held from the take on, so the buffer never blinks before read data drives
    wire logic rd_hold = busy & rd_req & (cs_act | ~bus.int_ack_n);
    // Byte lane write mask; 8-bit mode never takes the high lines
    wire logic hi_we = ~bus.bus8_mode & ~bhe_eff;
    wire logic [DATA_W-1:0] wr_mask = {{(DATA_W/2){hi_we}}, {(DATA_W/2){1'b1}}};

    // Buffer enable: combinational for reads, registered window for writes
    assign bus.data_buf_en_n = ~(rd_start | iack_start | rd_hold | buf_wr_q);
    assign bus.data_buf_dir = dir_q;
    assign bus.host_ready_ack_out = rdy_out_q;
    assign bus.host_ready_ack_oe_n = rdy_oe_n_q;
    assign bus.dev_data_out = rd_data_q;
    assign bus.dev_data_oe_n = rd_oe_n_q;
    assign bus.dev_high_oe_n = hi_oe_n_q;
    assign reg0_value = reg0_q;
    assign write_done = write_done_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            hrap_pkg::HRAP_IDLE: begin
                if (rd_start || iack_start) begin
                    state_d = hrap_pkg::HRAP_RD;
                end else if (wr_start) begin
                    state_d = hrap_pkg::HRAP_WR;
                end
            end
            hrap_pkg::HRAP_RD: begin
                if (cnt_q == hrap_pkg::READ_LAT) begin
                    state_d = hrap_pkg::HRAP_ACK;
                end
            end
            hrap_pkg::HRAP_WR: begin
                if (cnt_q == hrap_pkg::WR_SAMPLE_EDGE) begin
                    state_d = hrap_pkg::HRAP_ACK;
                end
            end
            hrap_pkg::HRAP_ACK: begin
                if (strobe_gone) begin
                    state_d = hrap_pkg::HRAP_DRV_HI;
                end
            end
            hrap_pkg::HRAP_DRV_HI: begin
                if (bus.host_ready_ack_n) begin
                    state_d = hrap_pkg::HRAP_WAIT_REL;
                end
            end
            hrap_pkg::HRAP_WAIT_REL: state_d = hrap_pkg::HRAP_IDLE;
            default: state_d = hrap_pkg::HRAP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sel_lat_q <= '0;
            cs_lat_q <= 1'b1;
            bhe_lat_q <= 1'b1;
        end else if (bus.addr_latch_strobe) begin
            sel_lat_q <= bus.reg_select;
            cs_lat_q <= bus.host_chip_sel_n;
            bhe_lat_q <= bus.byte_high_en_n;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_q <= hrap_pkg::HRAP_IDLE;
            cnt_q <= '0;
            is_iack_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_d == state_q && busy) ? cnt_q + 4'h1 : 4'h1;
            if (state_q == hrap_pkg::HRAP_IDLE) begin
                is_iack_q <= iack_start;
            end
        end
    end

    // Write window: enable on edge 3, sample and release on edge 6
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            buf_wr_q <= 1'b0;
            dir_q <= 1'b1;
            write_done_q <= 1'b0;
        end else begin
            write_done_q <= 1'b0;
            if (state_q == hrap_pkg::HRAP_WR && cnt_q == hrap_pkg::WR_BUF_ON_EDGE - 4'h1) begin
                buf_wr_q <= 1'b1;
            end else if (state_q == hrap_pkg::HRAP_WR && cnt_q == hrap_pkg::WR_SAMPLE_EDGE) begin
                buf_wr_q <= 1'b0;
                write_done_q <= 1'b1;
            end
            // Direction low through the write, held past the buffer enable
            if (wr_start) begin
                dir_q <= 1'b0;
            end else if (~wr_req && state_q != hrap_pkg::HRAP_WR) begin
                dir_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < NREG; i++) begin
                regs_q[i] <= '0;
            end
            reg0_q <= '0;
            vec_q <= VECTOR;
        end else begin
            if (state_q == hrap_pkg::HRAP_WR && cnt_q == hrap_pkg::WR_SAMPLE_EDGE) begin
                regs_q[sel_eff] <= (regs_q[sel_eff] & ~wr_mask) | (bus.bus_data & wr_mask);
                if (sel_eff == '0) begin
                    reg0_q <= (regs_q[0] & ~wr_mask) | (bus.bus_data & wr_mask);
                end
            end
            if (int_vec_load) begin
                vec_q <= int_vec_in;
            end
        end
    end

    // Read data is driven a cycle before ready and held until the strobe ends
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rd_data_q <= '0;
            rd_oe_n_q <= 1'b1;
            hi_oe_n_q <= 1'b1;
        end else if (state_q == hrap_pkg::HRAP_RD && cnt_q == hrap_pkg::READ_LAT - 4'h1) begin
            rd_data_q <= is_iack_q ? {{(DATA_W-hrap_pkg::VEC_W){1'b0}}, vec_q} : regs_q[sel_eff];
            rd_oe_n_q <= 1'b0;
            hi_oe_n_q <= bus.bus8_mode;
        end else if (~rd_req || (state_q == hrap_pkg::HRAP_DRV_HI)) begin
            rd_oe_n_q <= 1'b1;
            hi_oe_n_q <= 1'b1;
        end
    end

    // Ready: pulled low, then driven high until seen high, then floated
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdy_out_q <= 1'b1;
            rdy_oe_n_q <= 1'b1;
        end else if (state_d == hrap_pkg::HRAP_ACK) begin
            rdy_out_q <= 1'b0;
            rdy_oe_n_q <= 1'b0;
        end else if (state_d == hrap_pkg::HRAP_DRV_HI) begin
            rdy_out_q <= 1'b1;
            rdy_oe_n_q <= 1'b0;
        end else begin
            rdy_out_q <= 1'b1;
            rdy_oe_n_q <= 1'b1;
        end
    end
endmodule : hrap_device
`default_nettype wire

// >>> hrap_pkg.sv
// Package for the host register access port: widths, timing counts, states.
// Assumes a single 10 MHz core clock shared by both ends.
package hrap_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned SEL_W = 3;
    localparam int unsigned VEC_W = 8;
    // Write: buffer enable on 3rd rising edge, data sampled on 6th (the edge after the count reaches 5)
    localparam logic [3:0] WR_BUF_ON_EDGE = 4'h3;
    localparam logic [3:0] WR_SAMPLE_EDGE = 4'h5;
    // Host-side timings, then the device read latency and reset vector
    localparam int unsigned STROBE_HIGH_NS = 100;
    localparam int unsigned STROBE_HIGH_CYC =
        (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IACK_FIRST_NS = 150;
    localparam int unsigned IACK_FIRST_CYC =
        (IACK_FIRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RELEASE_MAX_NS = 1000;
    localparam int unsigned RELEASE_MAX_CYC = RELEASE_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned SKEW_MAX_NS = 10;
    localparam logic [3:0] READ_LAT = 4'h2;
    localparam logic [VEC_W-1:0] VEC_RESET = 8'h00;

    typedef enum logic [5:0] {
        HRAP_IDLE = 6'h01,
        HRAP_RD = 6'h02,
        HRAP_WR = 6'h04,
        HRAP_ACK = 6'h08,
        HRAP_DRV_HI = 6'h10,
        HRAP_WAIT_REL = 6'h20
    } hrap_dev_state_e;

    typedef enum logic [5:0] {
        HRAPH_IDLE = 6'h01,
        HRAPH_SETUP = 6'h02,
        HRAPH_STROBE = 6'h04,
        HRAPH_HOLD = 6'h08,
        HRAPH_GAP = 6'h10,
        HRAPH_IACK2 = 6'h20
    } hrap_host_state_e;
endpackage : hrap_pkg

// >>> hrap_if.sv
// Interface joining the host bus master and the adapter register port.
// Assumes both ends run on one clock; the testbench resolves shared wires.
`timescale 1ns/1ps
`default_nettype none
interface hrap_if;
    logic host_chip_sel_n;
    logic lower_strobe_n;
    logic upper_strobe_n;
    logic rd_strobe_n;
    logic wr_strobe_n;
    logic read_not_write;
    logic byte_high_en_n;
    logic [hrap_pkg::SEL_W-1:0] reg_select;
    logic addr_latch_strobe;
    logic int_ack_n;
    logic acknowledge_style_mode;
    logic bus8_mode;
    logic [hrap_pkg::DATA_W-1:0] host_data_out;
    logic host_data_oe_n;
    logic [hrap_pkg::DATA_W-1:0] dev_data_out;
    logic dev_data_oe_n;
    logic dev_high_oe_n;
    logic data_buf_en_n;
    logic data_buf_dir;
    logic host_ready_ack_out;
    logic host_ready_ack_oe_n;
    logic host_ready_ack_n;
    logic [hrap_pkg::DATA_W-1:0] bus_data;

    modport device (
        input host_chip_sel_n, lower_strobe_n, upper_strobe_n, rd_strobe_n, wr_strobe_n,
        input read_not_write, byte_high_en_n, reg_select, addr_latch_strobe, int_ack_n,
        input acknowledge_style_mode, bus8_mode, bus_data, host_ready_ack_n,
        output dev_data_out, dev_data_oe_n, dev_high_oe_n, data_buf_en_n, data_buf_dir,
        output host_ready_ack_out, host_ready_ack_oe_n
    );
    modport host (
        output host_chip_sel_n, lower_strobe_n, upper_strobe_n, rd_strobe_n, wr_strobe_n,
        output read_not_write, byte_high_en_n, reg_select, addr_latch_strobe, int_ack_n,
        output acknowledge_style_mode, bus8_mode, host_data_out, host_data_oe_n,
        input bus_data, host_ready_ack_n
    );
endinterface : hrap_if
`default_nettype wire

// >>> hrap_host.sv
// Host bus master end: runs one register read, write or interrupt
// acknowledge per request. Assumes the device end shares core_clk.
`timescale 1ns/1ps
`default_nettype none
module hrap_host #(
    parameter int unsigned DATA_W = hrap_pkg::DATA_W,
    parameter int unsigned SEL_W = hrap_pkg::SEL_W
) (
    input wire logic core_clk,
    input wire logic rst_b,
    hrap_if.host bus,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_iack,
    input wire logic [SEL_W-1:0] req_sel,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic mode_ack_style,
    input wire logic mode_8bit,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata
);
    hrap_pkg::hrap_host_state_e state_q;
    logic [3:0] cnt_q;
    logic cs_n_q, rd_n_q, wr_n_q, ds_n_q, rnw_q, iack_n_q, oe_n_q, wr_q, ia_q, mode_q;
    logic [SEL_W-1:0] sel_q;
    logic [DATA_W-1:0] wdata_q, rdata_q;
    logic rsp_q;
    wire logic rdy = ~bus.host_ready_ack_n;

    assign bus.host_chip_sel_n = cs_n_q;
    assign bus.rd_strobe_n = rd_n_q;
    assign bus.wr_strobe_n = wr_n_q;
    assign bus.lower_strobe_n = ds_n_q;
    assign bus.upper_strobe_n = ds_n_q;
    assign bus.read_not_write = rnw_q;
    assign bus.byte_high_en_n = 1'b0;
    assign bus.reg_select = sel_q;
    assign bus.addr_latch_strobe = 1'b1;
    assign bus.int_ack_n = iack_n_q;
    assign bus.acknowledge_style_mode = mode_q;
    assign bus.bus8_mode = mode_8bit;
    assign bus.host_data_out = wdata_q;
    assign bus.host_data_oe_n = oe_n_q;
    assign req_ready = (state_q == hrap_pkg::HRAPH_IDLE);
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_q <= hrap_pkg::HRAPH_IDLE;
            cnt_q <= '0;
            {cs_n_q, rd_n_q, wr_n_q, ds_n_q, iack_n_q, oe_n_q} <= 6'h3f;
            rnw_q <= 1'b1;
            wr_q <= 1'b0;
            ia_q <= 1'b0;
            mode_q <= 1'b0;
            sel_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            rsp_q <= 1'b0;
        end else begin
            rsp_q <= 1'b0;
            cnt_q <= cnt_q + 4'h1;
            case (state_q)
                hrap_pkg::HRAPH_IDLE: begin
                    if (req_valid) begin
                        sel_q <= req_sel;
                        wdata_q <= req_wdata;
                        rnw_q <= ~req_write | req_iack;
                        wr_q <= req_write & ~req_iack;
                        ia_q <= req_iack & ~mode_ack_style;
                        mode_q <= mode_ack_style;
                        state_q <= hrap_pkg::HRAPH_SETUP;
                    end
                end
                hrap_pkg::HRAPH_SETUP: begin
                    // Select and acknowledge never overlap
                    cs_n_q <= ia_q;
                    iack_n_q <= ~ia_q;
                    oe_n_q <= ~wr_q;
                    cnt_q <= '0;
                    if (ia_q) begin
                        rd_n_q <= 1'b1;
                        state_q <= hrap_pkg::HRAPH_IACK2;
                    end else begin
                        ds_n_q <= ~mode_q;
                        rd_n_q <= mode_q | wr_q;
                        wr_n_q <= mode_q | ~wr_q;
                        state_q <= hrap_pkg::HRAPH_STROBE;
                    end
                end
                hrap_pkg::HRAPH_IACK2: begin
                    // First pulse held three cycles, past its minimum width, then one gap
                    if (cnt_q == 4'(hrap_pkg::IACK_FIRST_CYC)) begin
                        iack_n_q <= 1'b1;
                    end else if (cnt_q == 4'(hrap_pkg::IACK_FIRST_CYC + hrap_pkg::STROBE_HIGH_CYC)) begin
                        iack_n_q <= 1'b0;
                        rd_n_q <= 1'b0;
                        state_q <= hrap_pkg::HRAPH_STROBE;
                    end
                end
                hrap_pkg::HRAPH_STROBE: begin
                    // Address and direction held until ready
                    if (rdy) begin
                        rdata_q <= bus.bus_data;
                        oe_n_q <= 1'b1;
                        cnt_q <= '0;
                        state_q <= hrap_pkg::HRAPH_HOLD;
                    end
                end
                hrap_pkg::HRAPH_HOLD: begin
                    // One cycle of margin, well inside the release limit
                    {cs_n_q, rd_n_q, wr_n_q, ds_n_q, iack_n_q} <= 5'h1f;
                    rsp_q <= 1'b1;
                    cnt_q <= '0;
                    state_q <= hrap_pkg::HRAPH_GAP;
                end
                hrap_pkg::HRAPH_GAP: begin
                    if (cnt_q >= 4'(hrap_pkg::STROBE_HIGH_CYC) && bus.host_ready_ack_n) begin
                        state_q <= hrap_pkg::HRAPH_IDLE;
                    end
                end
                default: state_q <= hrap_pkg::HRAPH_IDLE;
            endcase
        end
    end
endmodule : hrap_host
`default_nettype wire

// >>> hrap_monitor.sv
// Checker for the host register access port: watches the shared bus wires.
// Assumes one clock domain and a host end that keeps its own bus timing.
`timescale 1ns/1ps
`default_nettype none
module hrap_monitor (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic host_chip_sel_n,
    input wire logic lower_strobe_n,
    input wire logic upper_strobe_n,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic read_not_write,
    input wire logic int_ack_n,
    input wire logic acknowledge_style_mode,
    input wire logic bus8_mode,
    input wire logic dev_data_oe_n,
    input wire logic dev_high_oe_n,
    input wire logic data_buf_en_n,
    input wire logic data_buf_dir,
    input wire logic host_ready_ack_out,
    input wire logic host_ready_ack_oe_n,
    input wire logic host_ready_ack_n
);
    // Acknowledge style qualifies both data strobes with the direction line
    wire logic both_low = !lower_strobe_n && !upper_strobe_n;
    wire logic rd_req = acknowledge_style_mode ? (both_low && read_not_write) : !rd_strobe_n;
    wire logic wr_req = acknowledge_style_mode ? (both_low && !read_not_write) : !wr_strobe_n;
    wire logic rd_act = !host_chip_sel_n && rd_req;
    wire logic wr_act = !host_chip_sel_n && wr_req;
    wire logic bus_busy = (!host_chip_sel_n || !int_ack_n) && (rd_req || wr_req);

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_read_buf_comb: assert property ($rose(rd_act) |-> !data_buf_en_n)
        else $error("read buffer enable not low at read take");
    chk_read_ready_lat: assert property ($rose(rd_act) |-> ##[3:4] !host_ready_ack_n)
        else $error("read ready not low three cycles after take");
    chk_ready_after_data: assert property (rd_act && !host_ready_ack_n |-> !dev_data_oe_n)
        else $error("read ready low without read data driven");
    chk_read_data_hold: assert property (rd_act && !host_ready_ack_n ##1 rd_act
            |-> !host_ready_ack_n && !dev_data_oe_n)
        else $error("read data or ready dropped while strobe still low");
    chk_write_buf_third: assert property ($rose(wr_act) |-> data_buf_en_n ##1 data_buf_en_n
            ##1 data_buf_en_n ##[0:1] !data_buf_en_n)
        else $error("write buffer enable not on third edge");
    chk_buf_before_ready: assert property (wr_act && $fell(host_ready_ack_n) |-> data_buf_en_n)
        else $error("write ready asserted with buffer still enabled");
    chk_dir_write_low: assert property ($rose(wr_act) |-> ##[0:1] !data_buf_dir)
        else $error("direction not low after write strobe");
    chk_dir_write_high: assert property ($fell(wr_req) |-> ##[0:2] data_buf_dir)
        else $error("direction not high after write strobe rise");
    chk_ready_high_first: assert property ($rose(host_ready_ack_oe_n)
            |-> $past(host_ready_ack_out) && !$past(host_ready_ack_oe_n))
        else $error("ready released without being driven high");
    chk_high_float_8bit: assert property (bus8_mode && !dev_data_oe_n |-> dev_high_oe_n)
        else $error("upper data lines driven in eight-bit read");
    chk_release_bound: assert property ($fell(host_ready_ack_n) |-> ##[0:10] !bus_busy)
        else $error("host held strobes past release limit");
    chk_select_iack_excl: assert property (!(!int_ack_n && !host_chip_sel_n))
        else $error("select and interrupt acknowledge overlap");
    chk_strobe_skew: assert property (acknowledge_style_mode && !host_chip_sel_n
            |-> lower_strobe_n == upper_strobe_n)
        else $error("data strobes skewed in acknowledge style");

    cov_read: cover property ($rose(rd_act));
    cov_write_ack: cover property ($rose(wr_act) && acknowledge_style_mode);
    cov_read_8bit: cover property ($rose(rd_act) && bus8_mode);
    cov_iack: cover property ($fell(int_ack_n));
endmodule : hrap_monitor
`default_nettype wire

// >>> testbench.sv
// Testbench joining host and device ends of the register access port.
// Assumes the host end obeys its bus timing; the bench resolves shared wires.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_iack = 1'b0;
    logic [2:0] req_sel = 3'h0;
    logic [15:0] req_wdata = 16'h0000;
    logic mode_ack_style = 1'b0;
    logic mode_8bit = 1'b0;
    logic int_vec_load = 1'b0;
    logic [7:0] int_vec_in = 8'h00;
    logic req_ready;
    logic rsp_valid;
    logic [15:0] rsp_rdata;
    logic [15:0] reg0_value;
    logic write_done;
    logic [15:0] float_q = 16'h5a5a;
    logic [15:0] rd;
    int failures = 0;
    int samples_checked = 0;
    int writes_seen = 0;

    hrap_if bus_if();

    always #50 core_clk = ~core_clk;
    // Undriven lines toggle so a stale value can never pass for read data
    always @(posedge core_clk) float_q <= ~float_q;
    always @(negedge core_clk) if (write_done === 1'b1) writes_seen++;
    assign bus_if.host_ready_ack_n = bus_if.host_ready_ack_oe_n ? 1'b1 : bus_if.host_ready_ack_out;
    assign bus_if.bus_data[7:0] = !bus_if.host_data_oe_n ? bus_if.host_data_out[7:0] :
        !bus_if.dev_data_oe_n ? bus_if.dev_data_out[7:0] : float_q[7:0];
    assign bus_if.bus_data[15:8] = !bus_if.host_data_oe_n ? bus_if.host_data_out[15:8] :
        (!bus_if.dev_data_oe_n && !bus_if.dev_high_oe_n) ? bus_if.dev_data_out[15:8] :
        float_q[15:8];

    hrap_device i_hrap_device (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .bus(bus_if),
        .int_vec_load(int_vec_load),
        .int_vec_in(int_vec_in),
        .reg0_value(reg0_value),
        .write_done(write_done)
    );

    hrap_host i_hrap_host (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .bus(bus_if),
        .req_valid(req_valid),
        .req_write(req_write),
        .req_iack(req_iack),
        .req_sel(req_sel),
        .req_wdata(req_wdata),
        .mode_ack_style(mode_ack_style),
        .mode_8bit(mode_8bit),
        .req_ready(req_ready),
        .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata)
    );

    hrap_monitor i_hrap_monitor (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .host_chip_sel_n(bus_if.host_chip_sel_n),
        .lower_strobe_n(bus_if.lower_strobe_n),
        .upper_strobe_n(bus_if.upper_strobe_n),
        .rd_strobe_n(bus_if.rd_strobe_n),
        .wr_strobe_n(bus_if.wr_strobe_n),
        .read_not_write(bus_if.read_not_write),
        .int_ack_n(bus_if.int_ack_n),
        .acknowledge_style_mode(bus_if.acknowledge_style_mode),
        .bus8_mode(bus_if.bus8_mode),
        .dev_data_oe_n(bus_if.dev_data_oe_n),
        .dev_high_oe_n(bus_if.dev_high_oe_n),
        .data_buf_en_n(bus_if.data_buf_en_n),
        .data_buf_dir(bus_if.data_buf_dir),
        .host_ready_ack_out(bus_if.host_ready_ack_out),
        .host_ready_ack_oe_n(bus_if.host_ready_ack_oe_n),
        .host_ready_ack_n(bus_if.host_ready_ack_n)
    );

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // One host request; waits for the response under a bounded count
    task automatic access(input logic wr, input logic ia, input logic [2:0] sel,
            input logic [15:0] wd, output logic [15:0] rdata);
        int n;
        n = 0;
        @(negedge core_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_iack = ia;
        req_sel = sel;
        req_wdata = wd;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        check({15'h0000, rsp_valid}, 16'h0001, "response");
        rdata = rsp_rdata;
    endtask : access

    task automatic do_reset();
        @(negedge core_clk);
        rst_b = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        check({12'h000, bus_if.data_buf_en_n, bus_if.data_buf_dir, bus_if.host_ready_ack_oe_n,
            bus_if.dev_data_oe_n}, 16'h000f, "idle bus after reset");
    endtask : do_reset

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (6000) @(posedge core_clk);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        do_reset();
        for (int k = 0; k < 8; k++) begin
            access(1'b1, 1'b0, 3'(k), 16'h8001 + 16'(k) * 16'h1111, rd);
        end
        check(reg0_value, 16'h8001, "register 0 copy");
        for (int k = 7; k >= 0; k--) begin
            access(1'b0, 1'b0, 3'(k), 16'h0000, rd);
            check(rd, 16'h8001 + 16'(k) * 16'h1111, "separate strobe read");
        end
        $display("test separate_strobe done");
        // Mode pin is static in use: let the last read leave the bus first
        repeat (3) @(negedge core_clk);
        mode_8bit = 1'b1;
        access(1'b1, 1'b0, 3'h3, 16'hffee, rd);
        access(1'b0, 1'b0, 3'h3, 16'h0000, rd);
        check({8'h00, rd[7:0]}, 16'h00ee, "eight-bit read low byte");
        mode_8bit = 1'b0;
        access(1'b0, 1'b0, 3'h3, 16'h0000, rd);
        check(rd, 16'hb3ee, "upper byte kept after eight-bit write");
        $display("test eight_bit done");
        mode_ack_style = 1'b1;
        access(1'b1, 1'b0, 3'h5, 16'h4c3d, rd);
        access(1'b1, 1'b0, 3'h6, 16'hb2c4, rd);
        access(1'b0, 1'b0, 3'h5, 16'h0000, rd);
        check(rd, 16'h4c3d, "acknowledge style read");
        access(1'b0, 1'b0, 3'h6, 16'h0000, rd);
        check(rd, 16'hb2c4, "acknowledge style read");
        mode_ack_style = 1'b0;
        $display("test acknowledge_style done");
        @(negedge core_clk);
        int_vec_load = 1'b1;
        int_vec_in = 8'h5a;
        @(negedge core_clk);
        int_vec_load = 1'b0;
        access(1'b0, 1'b1, 3'h0, 16'h0000, rd);
        check({8'h00, rd[7:0]}, 16'h005a, "interrupt vector");
        access(1'b0, 1'b0, 3'h6, 16'h0000, rd);
        check(rd, 16'hb2c4, "read after acknowledge");
        $display("test interrupt_ack done");
        do_reset();
        access(1'b1, 1'b0, 3'h0, 16'h0f0f, rd);
        check(reg0_value, 16'h0f0f, "register 0 after second reset");
        access(1'b0, 1'b0, 3'h0, 16'h0000, rd);
        check(rd, 16'h0f0f, "read after second reset");
        check(16'(writes_seen), 16'h000c, "write sample pulses");
        $display("test second_reset done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
